// >>> rcdb_descriptor_builder.sv
// Purpose: builds the 96-bit descriptor that leads each completion packet
//          on the requester_completion_stream
// Assumes: completions, timeouts and aborts arrive already parsed
// Notes:   one beat carries the whole descriptor; a zero-length read adds
//          one dummy beat
// What this block does
// R1: unknown tag gives error code 0110
// R2: completion timeout gives code 1001, few fields valid
// R3: function reset abort gives code 1000
// R4: 13-bit byte count in bits 28:16
// R5: I/O completions carry byte count four
// R6: zero-length read: count one, dummy dword follows
// R7: memory read count is bytes still outstanding
// R8: split completions decrement count by returned bytes
// R9: bit 29 set only for locked reads
// R10: bit 30 marks last completion of request
// R11: user must not reuse tag before completion
// R12: 11-bit dword count in bits 42:32
// R13: dword count fixed for I/O and zero-length
// R14: completion status copied into bits 45:43
// R15: bit 46 flags a poisoned completion
// R16: requester ID in bits 63:48
// R17: tag in bits 71:64
// R18: completer ID in bits 87:72
// R19: traffic class in bits 91:89
// R20: attributes in bits 94:92
// R21: 12-byte descriptor leads every completion packet
// R22: lower address from pending table, bits 11:0
// R23: error code bits 15:12, normal and poisoned
// R24: spare bits 31, 88, 95 are zero
//
// Added by the designer: the strobed register port and the placing of the registers.
module rcdb_descriptor_builder (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [31:0]        reg_rdata_o,
  // outgoing requests to remember
  input  wire logic               rq_valid_i,
  output logic                    rq_ready_o,
  input  wire logic [7:0]         rq_tag_i,
  input  wire logic [11:0]        rq_addr_i,
  input  wire logic [12:0]        rq_bytes_i,
  input  wire logic [15:0]        rq_id_i,
  input  wire logic               rq_locked_i,
  // received completion or termination event
  input  wire logic               ev_valid_i,
  output logic                    ev_ready_o,
  input  rcdb_pkg::rcdb_kind_e    ev_kind_i,
  input  wire logic [7:0]         ev_tag_i,
  input  wire logic [2:0]         ev_status_i,
  input  wire logic               ev_poison_i,
  input  wire logic [15:0]        ev_cid_i,
  input  wire logic [10:0]        ev_dwords_i,
  input  wire logic [12:0]        ev_bytes_i,
  input  wire logic [2:0]         ev_tc_i,
  input  wire logic [2:0]         ev_attr_i,
  // requester_completion_stream
  output logic                    rc_valid_o,
  input  wire logic               rc_ready_i,
  output logic      [95:0]        rc_data_o,
  output logic                    rc_first_o,
  output logic                    rc_last_o,
  output logic                    rc_dummy_o
);
  import rcdb_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_LOOK, S_DESC, S_DUMMY} rcdb_state_e;

  rcdb_state_e state_r, state_nxt;
  rcdb_tbl_if  tbl ();

  // latched event
  rcdb_kind_e  ev_kind_r;
  logic [7:0]  ev_tag_r;
  logic [2:0]  ev_status_r;
  logic        ev_poison_r;
  logic [15:0] ev_cid_r;
  logic [10:0] ev_dw_r;
  logic [12:0] ev_bytes_r;
  logic [2:0]  ev_tc_r;
  logic [2:0]  ev_attr_r;

  // outputs and registers
  logic        rq_ready_r, ev_ready_r;
  logic        rc_valid_r, rc_first_r, rc_last_r, rc_dummy_r;
  logic [95:0] rc_data_r;
  logic [31:0] reg_rdata_r;
  logic        ctrl_en_r;
  logic [3:0]  last_err_r;
  logic [7:0]  last_tag_r;
  logic [15:0] count_r;
  logic [8:0]  pend_r;

  rcdb_tag_table u_table (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tbl     (tbl)
  );

  // handshakes
  wire rq_take = rq_valid_i && rq_ready_r;
  wire ev_take = ev_valid_i && ev_ready_r;
  wire beat_go = rc_valid_r && rc_ready_i;

  // decode of the looked-up entry
  rcdb_entry_s ent;
  assign ent = tbl.rdata;
  wire in_look   = (state_r == S_LOOK);
  wire is_io_rd  = (ev_kind_r == K_IO_RD);
  wire is_io_wr  = (ev_kind_r == K_IO_WR);
  wire is_zlr    = (ev_kind_r == K_ZLR);
  wire is_tmo    = (ev_kind_r == K_TIMEOUT);
  wire is_flr    = (ev_kind_r == K_FLR);
  wire is_abort  = is_tmo || is_flr;
  wire is_io     = is_io_rd || is_io_wr;
  wire hit       = ent.valid;
  wire rem_le    = (ent.remain <= ev_bytes_r);
  wire [12:0] rem_left = rem_le ? 13'h0000 : ent.remain - ev_bytes_r;

  // error code selection, aborts first
  wire [3:0] err_w =
    is_tmo      ? ERR_TIMEOUT :           // R2
    is_flr      ? ERR_FLR     :           // R3
    !hit        ? ERR_BAD_TAG :           // R1
    ev_poison_r ? ERR_POISON  :           // R23
                  ERR_NORMAL;

  // byte count selection
  wire [12:0] bc_w =
    is_io  ? BC_IO  :                     // R5
    is_zlr ? BC_ZLR :                     // R6
             ent.remain;                  // R7 R8

  // dword count selection
  wire [10:0] dw_w =
    (is_io_rd || is_zlr) ? DW_ONE  :      // R13
    is_io_wr             ? DW_ZERO :
                           ev_dw_r;       // R12

  // the request ends on an abort, an I/O or zero-length completion, a bad status or poison, or when no bytes remain
  wire done_w = is_abort || (hit && (is_io || is_zlr || rem_le
                || ev_status_r != 3'h0 || ev_poison_r));
  wire lock_w = hit && ent.locked && !is_abort;

  // descriptor assembly
  logic [95:0] desc_c;
  always_comb begin
    desc_c = '0;                                   // R24
    desc_c[POS_ADDR +: 12] = ent.lo_addr;          // R22
    desc_c[POS_ERR  +: 4]  = err_w;                // R23
    desc_c[POS_BC   +: 13] = bc_w;                 // R4
    desc_c[POS_LOCK]       = lock_w;               // R9
    desc_c[POS_DONE]       = done_w;               // R10
    desc_c[POS_DW   +: 11] = dw_w;                 // R12
    desc_c[POS_STAT +: 3]  = ev_status_r;          // R14
    desc_c[POS_POIS]       = ev_poison_r;          // R15
    desc_c[POS_RID  +: 16] = ent.req_id;           // R16
    desc_c[POS_TAG  +: 8]  = ev_tag_r;             // R17
    desc_c[POS_CID  +: 16] = ev_cid_r;             // R18
    desc_c[POS_TC   +: 3]  = ev_tc_r;              // R19
    desc_c[POS_ATTR +: 3]  = ev_attr_r;            // R20
  end

  // table port: updates while looking up, new requests while idle
  rcdb_entry_s upd_w, new_w;
  assign upd_w = '{valid: !done_w, locked: ent.locked, req_id: ent.req_id,
                   remain: rem_left,
                   lo_addr: ent.lo_addr + ev_bytes_r[11:0]};   // R8
  assign new_w = '{valid: 1'b1, locked: rq_locked_i, req_id: rq_id_i,
                   remain: rq_bytes_i, lo_addr: rq_addr_i};
  assign tbl.we    = (in_look && hit) || rq_take;
  assign tbl.waddr = in_look ? ev_tag_r : rq_tag_i;
  assign tbl.wdata = in_look ? upd_w : new_w;
  assign tbl.raddr = ev_tag_i;

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (ev_take) state_nxt = S_LOOK;
      S_LOOK:  state_nxt = S_DESC;
      S_DESC:  if (beat_go) state_nxt = is_zlr ? S_DUMMY : S_IDLE;  // R6
      S_DUMMY: if (beat_go) state_nxt = S_IDLE;
    endcase
  end

  // state register and ready flags
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r    <= S_IDLE;
      rq_ready_r <= 1'b0;
      ev_ready_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      rq_ready_r <= (state_nxt == S_IDLE);
      ev_ready_r <= (state_nxt == S_IDLE) && ctrl_en_r && !ev_take;
    end
  end

  // event capture
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ev_kind_r   <= K_MEM;
      ev_tag_r    <= '0;
      ev_status_r <= '0;
      ev_poison_r <= 1'b0;
      ev_cid_r    <= '0;
      ev_dw_r     <= '0;
      ev_bytes_r  <= '0;
      ev_tc_r     <= '0;
      ev_attr_r   <= '0;
    end else if (ev_take) begin
      ev_kind_r   <= ev_kind_i;
      ev_tag_r    <= ev_tag_i;
      ev_status_r <= ev_status_i;
      ev_poison_r <= ev_poison_i;
      ev_cid_r    <= ev_cid_i;
      ev_dw_r     <= ev_dwords_i;
      ev_bytes_r  <= ev_bytes_i;
      ev_tc_r     <= ev_tc_i;
      ev_attr_r   <= ev_attr_i;
    end
  end

  // stream beat flags, descriptor first, dummy dword last
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rc_valid_r <= 1'b0;
      rc_first_r <= 1'b0;
      rc_last_r  <= 1'b0;
      rc_dummy_r <= 1'b0;
    end else begin
      rc_valid_r <= (state_nxt == S_DESC) || (state_nxt == S_DUMMY); // R21
      rc_first_r <= (state_nxt == S_DESC);
      rc_last_r  <= (state_nxt == S_DUMMY) ||
                    ((state_nxt == S_DESC) && !is_zlr);
      rc_dummy_r <= (state_nxt == S_DUMMY);
    end
  end

  // beat data: the descriptor, then an all-zero dummy dword
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rc_data_r <= '0;
    end else if (in_look) begin
      rc_data_r <= desc_c;                                          // R21
    end else if (state_r == S_DESC && state_nxt == S_DUMMY) begin
      rc_data_r <= '0;                                              // R6
    end
  end

  // register decode
  wire sel_ctrl  = (reg_addr_i == REG_CTRL);
  wire sel_stat  = (reg_addr_i == REG_STAT);
  wire sel_count = (reg_addr_i == REG_COUNT);
  wire sel_pend  = (reg_addr_i == REG_PEND);
  wire busy_w    = (state_r != S_IDLE);
  wire retire_w  = in_look && hit && done_w;
  wire [31:0] rd_mux =
    sel_ctrl  ? {31'h0, ctrl_en_r} :
    sel_stat  ? {16'h0, last_tag_r, 3'h0, busy_w, last_err_r} :
    sel_count ? {16'h0, count_r} :
    sel_pend  ? {23'h0, pend_r} :
                32'h0;

  // control and status registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_en_r  <= CTRL_RST;
      last_err_r <= ERR_NORMAL;
      last_tag_r <= '0;
    end else begin
      if (reg_wr_i && sel_ctrl) ctrl_en_r <= reg_wdata_i[0];
      if (in_look) begin
        last_err_r <= err_w;
        last_tag_r <= ev_tag_r;
      end
    end
  end

  // descriptor counter, write clears; a count in that cycle still lands
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (reg_wr_i && sel_count) begin
      count_r <= {15'h0, in_look};
    end else if (in_look) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // number of pending requests
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else if (rq_take && !retire_w) begin
      pend_r <= pend_r + 9'h001;
    end else if (retire_w && !rq_take) begin
      pend_r <= pend_r - 9'h001;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_r <= '0;
    end else begin
      reg_rdata_r <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata_o = reg_rdata_r;
  assign rq_ready_o  = rq_ready_r;
  assign ev_ready_o  = ev_ready_r;
  assign rc_valid_o  = rc_valid_r;
  assign rc_first_o  = rc_first_r;
  assign rc_last_o   = rc_last_r;
  assign rc_dummy_o  = rc_dummy_r;
  assign rc_data_o   = rc_data_r;

  // checks on the produced descriptor
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_timeout_code: assert property (in_look && is_tmo |=> // R2
    rc_data_o[15:12] == 4'h9 && rc_data_o[30])
    else $error("timeout descriptor wrong");
  a_flr_code: assert property (in_look && is_flr |=> // R3
    rc_data_o[15:12] == 4'h8 && rc_data_o[30])
    else $error("abort descriptor wrong");
  a_bad_tag: assert property (in_look && !is_abort && !hit |=> // R1
    rc_data_o[15:12] == 4'h6)
    else $error("unknown tag not flagged");
  a_io_counts: assert property (in_look && is_io |=> // R5
    rc_data_o[28:16] == 13'h0004 && rc_data_o[42:32] == (is_io_rd ? 1 : 0))
    else $error("io counts wrong");
  a_zlr_dummy: assert property (beat_go && rc_first_o && is_zlr |=> // R6
    rc_valid_o && rc_dummy_o && rc_last_o && rc_data_o == 96'h0)
    else $error("dummy dword missing");
  a_mem_remain: assert property (in_look && ev_kind_r == K_MEM && hit |=> // R7
    rc_data_o[28:16] == $past(ent.remain))
    else $error("byte count not remaining");
  a_spare_zero: assert property (rc_valid_o && rc_first_o |-> // R24
    !rc_data_o[31] && !rc_data_o[88] && !rc_data_o[95])
    else $error("spare bits set");
  a_beat_hold: assert property (rc_valid_o && !rc_ready_i |=> // R21
    rc_valid_o && $stable(rc_data_o))
    else $error("beat dropped under stall");
  a_lock_clear: assert property (in_look && !ent.locked |=> // R9
    !rc_data_o[29])
    else $error("lock bit without locked read");
  a_tag_copy: assert property (ev_take ##2 1'b1 |-> // R17
    rc_data_o[71:64] == $past(ev_tag_i, 2))
    else $error("tag not copied");

  c_zlr: cover property (beat_go && rc_dummy_o);
  c_split: cover property (in_look && ev_kind_r == K_MEM && hit && !done_w);
  c_timeout: cover property (in_look && is_tmo);
  c_stall: cover property (rc_valid_o && !rc_ready_i);
endmodule

// >>> rcdb_descriptor_builder_tb.sv
// Purpose: self-checking bench of the completion descriptor builder
// Assumes: sink model on the stream; registers over the plain port
// Notes:   table rows first, then split, refusal and reset cases
module rcdb_descriptor_builder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rcdb_pkg::*;
  typedef struct packed {
    rcdb_kind_e  kind;
    logic        lk;
    logic [12:0] rb, eb;
    logic [10:0] edw;
    logic [2:0]  st;
    logic        ps;
    logic [3:0]  e;
    logic [12:0] bc;
    logic [10:0] dw;
    logic        dn;
    logic [95:0] m;
  } rcdb_row_s;
  // field masks: all but bit 47, no error code, abort fields, tag with done bit and error code
  localparam logic [95:0] M_ALL = 96'hFFFF_FFFF_FFFF_7FFF_FFFF_FFFF;
  localparam logic [95:0] M_NOE = 96'hFFFF_FFFF_FFFF_7FFF_FFFF_0FFF;
  localparam logic [95:0] M_ABT = 96'h0000_00FF_00FF_0000_4000_F000;
  localparam logic [95:0] M_TAG = 96'h0000_00FF_0000_0000_4000_F000;
  localparam logic [95:0] M_HI  = {{48{1'b1}}, 48'h0};
  logic clock_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, rq_tag_i = 8'h00, ev_tag_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic rq_valid_i = 1'b0, rq_ready_o, rq_locked_i = 1'b0;
  logic [11:0] rq_addr_i = 12'h000;
  logic [12:0] rq_bytes_i = 13'h0, ev_bytes_i = 13'h0;
  logic [15:0] rq_id_i = 16'h0, ev_cid_i = 16'h0;
  logic ev_valid_i = 1'b0, ev_ready_o, ev_poison_i = 1'b0, stall = 1'b0;
  rcdb_kind_e ev_kind_i = K_MEM;
  logic [2:0] ev_status_i = 3'h0, ev_tc_i = 3'h0, ev_attr_i = 3'h0;
  logic [10:0] ev_dwords_i = 11'h0;
  logic rc_valid_o, rc_ready_i, rc_first_o, rc_last_o, rc_dummy_o;
  logic [95:0] rc_data_o, desc;
  logic [7:0] ndesc, nd0;
  logic dum_ok, held_bad;
  int failures = 0, n_tests = 0, cyc = 0;
  rcdb_row_s rows [10];

  always #5 clock_i = ~clock_i;

  rcdb_descriptor_builder rcdb_descriptor_builder_i (.clock_i(clock_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rq_valid_i(rq_valid_i), .rq_ready_o(rq_ready_o), .rq_tag_i(rq_tag_i),
    .rq_addr_i(rq_addr_i), .rq_bytes_i(rq_bytes_i), .rq_id_i(rq_id_i),
    .rq_locked_i(rq_locked_i), .ev_valid_i(ev_valid_i),
    .ev_ready_o(ev_ready_o), .ev_kind_i(ev_kind_i), .ev_tag_i(ev_tag_i),
    .ev_status_i(ev_status_i), .ev_poison_i(ev_poison_i),
    .ev_cid_i(ev_cid_i), .ev_dwords_i(ev_dwords_i),
    .ev_bytes_i(ev_bytes_i), .ev_tc_i(ev_tc_i), .ev_attr_i(ev_attr_i),
    .rc_valid_o(rc_valid_o), .rc_ready_i(rc_ready_i),
    .rc_data_o(rc_data_o), .rc_first_o(rc_first_o),
    .rc_last_o(rc_last_o), .rc_dummy_o(rc_dummy_o));

  rcdb_sink rcdb_sink_i (.clock_i(clock_i), .rst_i(rst_i),
    .valid_i(rc_valid_o), .data_i(rc_data_o), .first_i(rc_first_o),
    .last_i(rc_last_o), .dummy_i(rc_dummy_o), .ready_o(rc_ready_i),
    .stall_i(stall), .desc_o(desc), .ndesc_o(ndesc), .dum_ok_o(dum_ok),
    .held_bad_o(held_bad));

  // closing report, reached from the main sequence or the cycle ceiling
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // cycle ceiling against hangs
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic chk_desc(input logic [95:0] e, input logic [95:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected desc at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected word at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  function automatic rcdb_row_s rw(rcdb_kind_e k, logic lk, logic [12:0] rb,
      logic [12:0] eb, logic [10:0] edw, logic [2:0] st, logic ps,
      logic [3:0] e, logic [12:0] bc, logic [10:0] dw, logic dn,
      logic [95:0] m);
    rw = '{k, lk, rb, eb, edw, st, ps, e, bc, dw, dn, m};
  endfunction

  // register write and read, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    v = reg_rdata_o;
  endtask

  // hand one request to the pending table
  task automatic rq_put(input rcdb_row_s r, input logic [7:0] tg,
      input logic [11:0] ad);
    @(posedge clock_i);
    rq_valid_i <= 1'b1;
    rq_tag_i <= tg;
    rq_addr_i <= ad;
    rq_bytes_i <= r.rb;
    rq_id_i <= {8'hA5, tg};
    rq_locked_i <= r.lk;
    do @(negedge clock_i); while (rq_ready_o !== 1'b1);
    @(posedge clock_i);
    rq_valid_i <= 1'b0;
  endtask

  // raise one event; derived fields come from the tag
  task automatic ev_put(input rcdb_row_s r, input logic [7:0] tg);
    nd0 = ndesc;
    @(posedge clock_i);
    ev_valid_i <= 1'b1;
    ev_kind_i <= r.kind;
    ev_tag_i <= tg;
    ev_status_i <= r.st;
    ev_poison_i <= r.ps;
    ev_cid_i <= {tg, 8'h3C};
    ev_dwords_i <= r.edw;
    ev_bytes_i <= r.eb;
    ev_tc_i <= tg[2:0];
    ev_attr_i <= tg[5:3];
  endtask

  // wait for take, descriptor and idle, then compare the descriptor
  task automatic ev_end(input rcdb_row_s r, input logic [7:0] tg,
      input logic [11:0] ad);
    logic [95:0] x, g;
    // waits end on the cycle ceiling, which counts as a mismatch
    do @(negedge clock_i); while (ev_ready_o !== 1'b1);
    @(posedge clock_i);
    ev_valid_i <= 1'b0;
    while (ndesc === nd0) @(negedge clock_i);
    do @(negedge clock_i); while (ev_ready_o !== 1'b1);
    x = {1'b0, tg[5:3], tg[2:0], 1'b0, tg, 8'h3C, tg, 8'hA5, tg, 1'b0,
         r.ps, r.st, r.dw, 1'b0, r.dn, r.lk, r.bc, r.e, ad};
    x = x & r.m;
    g = desc & r.m;
    chk_desc(x & M_HI, g & M_HI);
    chk_desc(x & ~M_HI, g & ~M_HI);
  endtask

  initial begin
    rows = '{
      rw(K_MEM,     0, 13'h40, 13'h40, 11'h10, 3'h0, 0, 4'h0, 13'h40,
         11'h10, 1, M_ALL),
      rw(K_MEM,     1, 13'h8,  13'h8,  11'h2,  3'h0, 1, 4'h1, 13'h8,
         11'h2, 1, M_ALL),
      rw(K_IO_RD,   0, 13'h40, 13'h4,  11'h0,  3'h0, 0, 4'h0, 13'h4,
         11'h1, 1, M_ALL),
      rw(K_IO_WR,   0, 13'h40, 13'h0,  11'h5,  3'h0, 0, 4'h0, 13'h4,
         11'h0, 1, M_ALL),
      rw(K_ZLR,     0, 13'h40, 13'h0,  11'h0,  3'h0, 0, 4'h0, 13'h1,
         11'h1, 1, M_ALL),
      rw(K_MEM,     0, 13'h1000, 13'h0, 11'h0, 3'h1, 0, 4'h0, 13'h1000,
         11'h0, 1, M_NOE),
      rw(K_MEM,     0, 13'h1000, 13'h0, 11'h0, 3'h2, 0, 4'h0, 13'h1000,
         11'h0, 1, M_NOE),
      rw(K_MEM,     0, 13'h1000, 13'h0, 11'h0, 3'h4, 0, 4'h0, 13'h1000,
         11'h0, 1, M_NOE),
      rw(K_TIMEOUT, 0, 13'h40, 13'h0,  11'h0,  3'h0, 0, 4'h9, 13'h0,
         11'h0, 1, M_ABT),
      rw(K_FLR,     0, 13'h40, 13'h0,  11'h0,  3'h0, 0, 4'h8, 13'h0,
         11'h0, 1, M_ABT)};
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(REG_CTRL, d);
    chk32(32'h1, d & 32'h1);
    // each row uses a fresh tag, never reused while live
    foreach (rows[i]) begin
      rq_put(rows[i], 8'h10 + i[7:0], {4'hA, 8'h10 + i[7:0]});
      ev_put(rows[i], 8'h10 + i[7:0]);
      ev_end(rows[i], 8'h10 + i[7:0], {4'hA, 8'h10 + i[7:0]});
      if (rows[i].kind == K_ZLR) chk32(32'h1, {31'h0, dum_ok});
    end
    // split read: second completion under a stalling sink
    rq_put(rw(K_MEM, 0, 13'h100, 0, 0, 0, 0, 0, 0, 0, 0, 0), 8'h40, 12'h0F0);
    rd(REG_PEND, d);
    chk32(32'h1, d);
    ev_put(rw(K_MEM, 0, 0, 13'h80, 11'h20, 0, 0, 0, 0, 0, 0, 0), 8'h40);
    ev_end(rw(K_MEM, 0, 0, 0, 11'h20, 0, 0, 0, 13'h100, 11'h20, 0, M_ALL),
           8'h40, 12'h0F0);
    stall <= 1'b1;
    ev_put(rw(K_MEM, 0, 0, 13'h80, 11'h20, 0, 0, 0, 0, 0, 0, 0), 8'h40);
    ev_end(rw(K_MEM, 0, 0, 0, 11'h20, 0, 0, 0, 13'h80, 11'h20, 1, M_ALL),
           8'h40, 12'h170);
    stall <= 1'b0;
    chk32(32'h0, {31'h0, held_bad});
    // unknown tag held off while disabled, then let through
    wr(REG_CTRL, 32'h0);
    ev_put(rw(K_MEM, 0, 0, 13'h4, 11'h1, 0, 0, 0, 0, 0, 0, 0), 8'h77);
    repeat (8) @(negedge clock_i);
    chk32(32'h0, {31'h0, ev_ready_o});
    wr(REG_CTRL, 32'h1);
    ev_end(rw(K_MEM, 0, 0, 0, 0, 0, 0, 4'h6, 0, 0, 0, M_TAG),
           8'h77, 12'h0);
    rd(REG_STAT, d);
    chk32(32'h0000_7706, d & 32'h0000_FF1F);
    rd(8'h10, d);
    chk32(32'h0, d);
    rd(REG_PEND, d);
    chk32(32'h0, d);
    rd(REG_COUNT, d);
    chk32(32'hD, d);
    wr(REG_COUNT, 32'h0);
    rd(REG_COUNT, d);
    chk32(32'h0, d);
    // reset in mid-flight
    rq_put(rows[0], 8'h60, 12'h060);
    ev_put(rows[0], 8'h60);
    repeat (2) @(negedge clock_i);
    @(posedge clock_i);
    rst_i <= 1'b1;
    ev_valid_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk32(32'h0, {29'h0, rc_valid_o, rq_ready_o, ev_ready_o});
    @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    chk32(32'h3, {29'h0, rc_valid_o, rq_ready_o, ev_ready_o});
    rd(REG_CTRL, d);
    chk32(32'h1, d & 32'h1);
    give_verdict();
  end
endmodule

// >>> rcdb_pkg.sv
// Purpose: shared constants and types of the completion descriptor builder
// Assumes: one 100 MHz user clock, 96-bit descriptor, 8-bit tags
// Notes:   field positions are bit indices inside the descriptor word
package rcdb_pkg;

  // widths
  localparam int DESC_W = 96;
  localparam int TAG_W  = 8;
  localparam int BC_W   = 13;
  localparam int DW_W   = 11;
  localparam int AW     = 8;

  // completion kinds handed in by the receive path
  typedef enum logic [2:0] {
    K_MEM, K_IO_RD, K_IO_WR, K_ZLR, K_TIMEOUT, K_FLR
  } rcdb_kind_e;

  // error codes
  localparam logic [3:0] ERR_NORMAL  = 4'h0;
  localparam logic [3:0] ERR_POISON  = 4'h1;
  localparam logic [3:0] ERR_BAD_TAG = 4'h6;
  localparam logic [3:0] ERR_FLR     = 4'h8;
  localparam logic [3:0] ERR_TIMEOUT = 4'h9;

  // descriptor field positions
  localparam int POS_ADDR = 0;
  localparam int POS_ERR  = 12;
  localparam int POS_BC   = 16;
  localparam int POS_LOCK = 29;
  localparam int POS_DONE = 30;
  localparam int POS_SP0  = 31;
  localparam int POS_DW   = 32;
  localparam int POS_STAT = 43;
  localparam int POS_POIS = 46;
  localparam int POS_RID  = 48;
  localparam int POS_TAG  = 64;
  localparam int POS_CID  = 72;
  localparam int POS_SP1  = 88;
  localparam int POS_TC   = 89;
  localparam int POS_ATTR = 92;
  localparam int POS_SP2  = 95;

  // fixed counts
  localparam logic [12:0] BC_IO   = 13'h0004;
  localparam logic [12:0] BC_ZLR  = 13'h0001;
  localparam logic [10:0] DW_ONE  = 11'h001;
  localparam logic [10:0] DW_ZERO = 11'h000;

  // register offsets and reset values
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam logic [7:0]  REG_COUNT = 8'h08;
  localparam logic [7:0]  REG_PEND  = 8'h0C;
  localparam logic        CTRL_RST  = 1'b1;

  // one pending request
  typedef struct packed {
    logic        valid;
    logic        locked;
    logic [15:0] req_id;
    logic [12:0] remain;
    logic [11:0] lo_addr;
  } rcdb_entry_s;

endpackage

// >>> rcdb_sink.sv
// Purpose: user-side model that takes beats off the completion stream
// Assumes: ready comes from a flop phase, so it moves just after an edge
// Notes:   flags any unserved beat that drops or changes before it is taken
module rcdb_sink (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // stream from the builder
  input  wire logic        valid_i,
  input  wire logic [95:0] data_i,
  input  wire logic        first_i,
  input  wire logic        last_i,
  input  wire logic        dummy_i,
  output logic             ready_o,
  // control and observation
  input  wire logic        stall_i,
  output logic [95:0]      desc_o,
  output logic [7:0]       ndesc_o,
  output logic             dum_ok_o,
  output logic             held_bad_o
);
  logic [1:0]  ph_r;
  logic        pend_r;
  logic [95:0] prev_r;
  logic        zl_r;
  wire         take = valid_i && ready_o;
  // when stalling, accept only one cycle in four
  assign ready_o = !stall_i || (ph_r == 2'h3);
  // capture descriptors and dummy beats
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r       <= 2'h0;
      pend_r     <= 1'b0;
      prev_r     <= 96'h0;
      desc_o     <= 96'h0;
      ndesc_o    <= 8'h00;
      dum_ok_o   <= 1'b0;
      held_bad_o <= 1'b0;
      zl_r       <= 1'b0;
    end else begin
      ph_r   <= ph_r + 2'h1;
      pend_r <= valid_i && !ready_o;
      prev_r <= data_i;
      if (pend_r && (!valid_i || data_i != prev_r)) held_bad_o <= 1'b1;
      if (take && first_i) begin
        desc_o  <= data_i;
        ndesc_o <= ndesc_o + 8'h01;
      end
      if (take && dummy_i) dum_ok_o <= (data_i == 96'h0) && last_i;
      // a descriptor beat without last must be followed by a dummy beat
      if (take && zl_r != dummy_i) held_bad_o <= 1'b1;
      if (take) zl_r <= first_i && !last_i;
    end
  end
endmodule

// >>> rcdb_tag_table.sv
// Purpose: table of pending non-posted requests, one entry per tag
// Assumes: read data come out of a register one cycle after the address
// Notes:   only the valid bits and the read register are reset; a read sees the old entry on a
//          same-cycle write to the same tag
module rcdb_tag_table (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // table port
  rcdb_tbl_if.store tbl
);
  import rcdb_pkg::*;

  rcdb_entry_s mem_r [0:255];
  logic [255:0] vld_r;
  rcdb_entry_s  rdata_r;

  // entry storage
  always_ff @(posedge clock_i) begin
    if (tbl.we) begin
      mem_r[tbl.waddr] <= tbl.wdata;
    end
  end

  // valid bits
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      vld_r <= '0;
    end else if (tbl.we) begin
      vld_r[tbl.waddr] <= tbl.wdata.valid;
    end
  end

  // registered read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r       <= mem_r[tbl.raddr];
      rdata_r.valid <= vld_r[tbl.raddr];
    end
  end

  assign tbl.rdata = rdata_r;
endmodule

// >>> rcdb_tbl_if.sv
// Purpose: port bundle between the builder and its pending-request table
// Assumes: one write port, one registered read port
// Notes:   read data belong to the address of the previous cycle
interface rcdb_tbl_if;
  logic                 we;
  logic [7:0]           waddr;
  rcdb_pkg::rcdb_entry_s wdata;
  logic [7:0]           raddr;
  rcdb_pkg::rcdb_entry_s rdata;

  modport user  (output we, waddr, wdata, raddr, input rdata);
  modport store (input we, waddr, wdata, raddr, output rdata);
endinterface
